// File: rtl/ibm_mux.sv
// Interleaved receive backplane multiplexer with per-port word FIFOs
`timescale 1ns/10ps
`include "ibm_consts.svh"

// ****************************************************************
// Word FIFO
// ****************************************************************
module ibm_fifo #(
  parameter int WIDTH = `IBM_FIFO_WIDTH,
  parameter int DEPTH = `IBM_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Level flags
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW:0] cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);

  assign full = (cnt_reg == (AW+1)'(DEPTH));
  assign in_ready = ~full;
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      cnt_reg <= cnt_next;
    end
  end

  // Storage has no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
endmodule : ibm_fifo

// ****************************************************************
// Multiplexer top
// ****************************************************************
// Overview of operation
// - Ganged mode: each port's data and signaling pins float outside its slots.
// - Default mode: ports are interleaved inside and driven on one pin.
// - A global gang bit picks ganged or internal; internal after reset.
// - Channel block outputs follow the receive and transmit system clocks.
// - Two identical multiplexers: ports 1 to 8 and ports 9 to 16.
// - Global transceiver control register holds the gang selection.
// - Global framer control register sets ports per bus and bus rate.
// - Per-port receive control enables interleave; ports 1 and 9 pick channel or frame.
// - Per-port transmit control enables interleave; the frame bit of ports 1 and 9 holds the slot on one port.
// - 4 MHz internal: odd pins carry a port pair; even pins idle.
// - 8 MHz internal: pins 1, 5, 9, 13 carry four ports each.
// - 16 MHz internal: pin 1 carries ports 1-8, pin 9 ports 9-16.
// - Normal use: each pin carries its own port; every such pin stays driven.
module ibm_mux (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Per-port words from the framers: signaling byte high, data byte low
  input wire logic [15:0] src_valid,
  input wire logic [15:0][15:0] src_data,
  output logic [15:0] src_ready,
  // System clock pins, one per multiplexer
  input wire logic [1:0] rx_system_clock,
  input wire logic [1:0] tx_system_clock,
  // Backplane pins
  output logic [15:0] rx_serial_out,
  output logic [15:0] rx_serial_oe,
  output logic [15:0] rx_signaling_out,
  output logic [15:0] rx_signaling_oe,
  output logic [15:0] rx_channel_block,
  output logic [15:0] tx_channel_block
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] gtcr_reg;
  logic [7:0] gfcr_reg;
  logic [7:0] rx_ctrl_reg [`IBM_PORTS];
  logic [7:0] tx_ctrl_reg [`IBM_PORTS];
  logic [31:0] prdata_reg;
  logic [15:0] fifo_vld;
  logic [15:0] fifo_full;
  logic [15:0] pop;
  logic [15:0] fifo_word [`IBM_PORTS];

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire [13:0] idx = paddr[`IBM_ADDR_HI:`IBM_ADDR_LO];
  wire [3:0] port_sel = idx[`IBM_PORT_HI:`IBM_PORT_LO];
  wire [8:0] low_idx = idx[8:0];
  wire in_range = ~idx[`IBM_IDX_TOP];
  wire glob = in_range & (port_sel == 4'h0);
  wire hit_gtcr = glob & (low_idx == `IBM_IDX_GTCR);
  wire hit_gfcr = glob & (low_idx == `IBM_IDX_GFCR);
  wire hit_stat = glob & (low_idx == `IBM_IDX_STATUS);
  wire hit_rx = in_range & (low_idx == `IBM_IDX_RX_CTRL);
  wire hit_tx = in_range & (low_idx == `IBM_IDX_TX_CTRL);
  wire mapped = hit_gtcr | hit_gfcr | hit_stat | hit_rx | hit_tx;
  wire setup_ph = psel & ~penable;
  wire access_ph = psel & penable;
  wire wr_en = access_ph & pwrite & mapped;
  wire [31:0] status_word = {fifo_full, ~fifo_vld};
  wire [31:0] rd_val = hit_gtcr ? {24'h00_0000, gtcr_reg} :
                       hit_gfcr ? {24'h00_0000, gfcr_reg} :
                       hit_stat ? status_word :
                       hit_rx ? {24'h00_0000, rx_ctrl_reg[port_sel]} :
                       hit_tx ? {24'h00_0000, tx_ctrl_reg[port_sel]} :
                       32'h0000_0000;

  assign pready = 1'b1;
  assign pslverr = access_ph & ~mapped;
  assign prdata = prdata_reg;

  // Read data captured in setup phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_ph & ~pwrite) begin
      prdata_reg <= rd_val;
    end
  end

  // ****************************************************************
  // Global and per-port control registers
  // ****************************************************************
  // Gang selection storage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gtcr_reg <= `IBM_CTRL_RST;
    end else if (wr_en & hit_gtcr) begin
      gtcr_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gfcr_reg <= `IBM_CTRL_RST;
    end else if (wr_en & hit_gfcr) begin
      gfcr_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `IBM_PORTS; i++) begin
        rx_ctrl_reg[i] <= `IBM_CTRL_RST;
        tx_ctrl_reg[i] <= `IBM_CTRL_RST;
      end
    end else if (wr_en & hit_rx) begin
      rx_ctrl_reg[port_sel] <= pwdata[7:0];
    end else if (wr_en & hit_tx) begin
      tx_ctrl_reg[port_sel] <= pwdata[7:0];
    end
  end

  // ****************************************************************
  // Rate and mode decode
  // ****************************************************************
  wire gang = gtcr_reg[`IBM_GANG_BIT];
  wire [1:0] rate_code = gfcr_reg[`IBM_RATE_HI:`IBM_RATE_LO];
  wire ibm_pkg::ibm_rate_t rate = ibm_pkg::ibm_rate_t'(rate_code);
  wire [2:0] grp_mask = (rate == ibm_pkg::IBM_RATE_4M) ? `IBM_MASK_4M :
                        (rate == ibm_pkg::IBM_RATE_8M) ? `IBM_MASK_8M :
                        `IBM_MASK_16M;

  // ****************************************************************
  // System clock synchronisers
  // ****************************************************************
  logic [3:0] clk_s1_reg;
  logic [3:0] clk_s2_reg;
  logic [3:0] clk_s3_reg;
  wire [3:0] clk_rise = clk_s2_reg & ~clk_s3_reg;
  wire [1:0] rx_edge = clk_rise[1:0];
  wire [1:0] tx_edge = clk_rise[3:2];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_s1_reg <= 4'h0;
      clk_s2_reg <= 4'h0;
      clk_s3_reg <= 4'h0;
    end else begin
      clk_s1_reg <= {tx_system_clock, rx_system_clock};
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
    end
  end

  // ****************************************************************
  // Slot sequencers, one per multiplexer
  // ****************************************************************
  logic [2:0] bit_reg [`IBM_GROUPS];
  logic [2:0] pidx_reg [`IBM_GROUPS];
  logic [4:0] chan_reg [`IBM_GROUPS];
  logic [2:0] tbit_reg [`IBM_GROUPS];
  logic [2:0] tpidx_reg [`IBM_GROUPS];
  logic [2:0] bit_next [`IBM_GROUPS];
  logic [2:0] pidx_next [`IBM_GROUPS];
  logic [4:0] chan_next [`IBM_GROUPS];
  logic [2:0] tbit_next [`IBM_GROUPS];
  logic [2:0] tpidx_next [`IBM_GROUPS];
  logic [1:0] byte_end;

  for (genvar g = 0; g < `IBM_GROUPS; g++) begin : g_grp
    wire frame_mode = rx_ctrl_reg[g*`IBM_LANES][`IBM_FRM_BIT];
    wire tframe_mode = tx_ctrl_reg[g*`IBM_LANES][`IBM_FRM_BIT];
    wire last_port = (pidx_reg[g] == grp_mask);
    wire last_chan = (chan_reg[g] == `IBM_SLOT_LAST);
    wire [2:0] pidx_inc = last_port ? 3'h0 : pidx_reg[g] + 3'h1;
    wire tbyte_end = tx_edge[g] & (tbit_reg[g] == `IBM_BIT_LAST);
    wire [2:0] tpidx_inc = (tpidx_reg[g] == grp_mask) ? 3'h0 : tpidx_reg[g] + 3'h1;
    assign byte_end[g] = rx_edge[g] & (bit_reg[g] == `IBM_BIT_LAST);
    assign bit_next[g] = rx_edge[g] ? bit_reg[g] + 3'h1 : bit_reg[g];
    // Ascending port order per slot or frame
    assign pidx_next[g] = ~byte_end[g] ? pidx_reg[g] :
                          (~frame_mode | last_chan) ? pidx_inc : pidx_reg[g];
    assign chan_next[g] = ~byte_end[g] ? chan_reg[g] :
                          (frame_mode | last_port) ? chan_reg[g] + 5'h01 : chan_reg[g];
    // Transmit side paced by its own clock
    assign tbit_next[g] = tx_edge[g] ? tbit_reg[g] + 3'h1 : tbit_reg[g];
    assign tpidx_next[g] = tbyte_end ? (tframe_mode ? tpidx_reg[g] : tpidx_inc) :
                           tpidx_reg[g];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int g = 0; g < `IBM_GROUPS; g++) begin
        bit_reg[g] <= 3'h0;
        pidx_reg[g] <= 3'h0;
        chan_reg[g] <= 5'h00;
        tbit_reg[g] <= 3'h0;
        tpidx_reg[g] <= 3'h0;
      end
    end else begin
      bit_reg <= bit_next;
      pidx_reg <= pidx_next;
      chan_reg <= chan_next;
      tbit_reg <= tbit_next;
      tpidx_reg <= tpidx_next;
    end
  end

  // ****************************************************************
  // Per-port FIFOs, shifters and pin steering
  // ****************************************************************
  logic [7:0] shd_reg [`IBM_PORTS];
  logic [7:0] shs_reg [`IBM_PORTS];
  logic [7:0] shd_next [`IBM_PORTS];
  logic [7:0] shs_next [`IBM_PORTS];
  logic [15:0] data_msb;
  logic [15:0] sig_msb;
  logic [15:0] ser_next;
  logic [15:0] sig_next;
  logic [15:0] oe_next;
  logic [15:0] rblk_next;
  logic [15:0] tblk_next;

  for (genvar p = 0; p < `IBM_PORTS; p++) begin : g_port
    localparam int G = p / `IBM_LANES;
    localparam logic [2:0] LANE = 3'(p % `IBM_LANES);
    wire rx_ilv = rx_ctrl_reg[p][`IBM_EN_BIT];
    wire tx_ilv = tx_ctrl_reg[p][`IBM_EN_BIT];
    wire [2:0] slot_lane = LANE & grp_mask;
    wire owner_cur = (slot_lane == pidx_reg[G]);
    wire owner_nxt = (slot_lane == pidx_next[G]);
    wire lead = (slot_lane == 3'h0);
    wire [3:0] src_port = {1'(G), (LANE & ~grp_mask) | pidx_reg[G]};
    wire load = byte_end[G] & (~rx_ilv | owner_nxt);
    wire [15:0] word = fifo_vld[p] ? fifo_word[p] : {`IBM_IDLE_BYTE, `IBM_IDLE_BYTE};

    ibm_fifo #(
      .WIDTH(`IBM_FIFO_WIDTH),
      .DEPTH(`IBM_FIFO_DEPTH)
    ) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .in_valid(src_valid[p]),
      .in_ready(src_ready[p]),
      .in_data(src_data[p]),
      .out_valid(fifo_vld[p]),
      .out_ready(pop[p]),
      .out_data(fifo_word[p]),
      .full(fifo_full[p])
    );

    assign pop[p] = load;
    assign shd_next[p] = load ? word[7:0] :
                         rx_edge[G] ? {shd_reg[p][6:0], 1'b1} : shd_reg[p];
    assign shs_next[p] = load ? word[15:8] :
                         rx_edge[G] ? {shs_reg[p][6:0], 1'b1} : shs_reg[p];
    assign data_msb[p] = shd_reg[p][7];
    assign sig_msb[p] = shs_reg[p][7];
    // Internal mode takes the current owner onto the lead pin
    // Normal use drives the port's own stream
    assign ser_next[p] = (rx_ilv & ~gang) ? data_msb[src_port] : data_msb[p];
    assign sig_next[p] = (rx_ilv & ~gang) ? sig_msb[src_port] : sig_msb[p];
    // Ganged pins float outside own slots
    // Non-lead pins idle in internal mode
    assign oe_next[p] = ~rx_ilv ? 1'b1 : gang ? owner_cur : lead;
    // Channel blocks follow the system clock slots
    assign rblk_next[p] = rx_ilv & ~owner_cur;
    assign tblk_next[p] = tx_ilv & ((LANE & grp_mask) != tpidx_reg[G]);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `IBM_PORTS; i++) begin
        shd_reg[i] <= `IBM_IDLE_BYTE;
        shs_reg[i] <= `IBM_IDLE_BYTE;
      end
    end else begin
      shd_reg <= shd_next;
      shs_reg <= shs_next;
    end
  end

  // ****************************************************************
  // Registered pin outputs
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_serial_out <= 16'h0000;
      rx_serial_oe <= 16'h0000;
      rx_signaling_out <= 16'h0000;
      rx_signaling_oe <= 16'h0000;
      rx_channel_block <= 16'h0000;
      tx_channel_block <= 16'h0000;
    end else begin
      rx_serial_out <= ser_next;
      rx_serial_oe <= oe_next;
      rx_signaling_out <= sig_next;
      rx_signaling_oe <= oe_next;
      rx_channel_block <= rblk_next;
      tx_channel_block <= tblk_next;
    end
  end
endmodule : ibm_mux

// File: include/ibm_consts.svh
// Constants for the interleaved backplane multiplexer
`ifndef IBM_CONSTS_SVH
`define IBM_CONSTS_SVH
`define IBM_ADDR_HI 15
`define IBM_ADDR_LO 2
`define IBM_PORT_HI 12
`define IBM_PORT_LO 9
`define IBM_IDX_TOP 13
`define IBM_IDX_RX_CTRL 9'h088
`define IBM_IDX_GTCR 9'h0f0
`define IBM_IDX_GFCR 9'h0f1
`define IBM_IDX_STATUS 9'h0f2
`define IBM_IDX_TX_CTRL 9'h188
`define IBM_GANG_BIT 0
`define IBM_RATE_HI 1
`define IBM_RATE_LO 0
`define IBM_EN_BIT 0
`define IBM_FRM_BIT 1
`define IBM_CTRL_RST 8'h00
`define IBM_BIT_LAST 3'h7
`define IBM_SLOT_LAST 5'h1f
`define IBM_MASK_4M 3'h1
`define IBM_MASK_8M 3'h3
`define IBM_MASK_16M 3'h7
`define IBM_IDLE_BYTE 8'hff
`define IBM_FIFO_WIDTH 16
`define IBM_FIFO_DEPTH 8
`define IBM_PORTS 16
`define IBM_LANES 8
`define IBM_GROUPS 2
`endif

// File: include/ibm_pkg.sv
// Types for the interleaved backplane multiplexer
package ibm_pkg;
  // Backplane rate selection
  typedef enum logic [1:0] {
    IBM_RATE_4M,
    IBM_RATE_8M,
    IBM_RATE_16M,
    IBM_RATE_RSV
  } ibm_rate_t;
endpackage : ibm_pkg

// File: tb/ibm_mux_monitor.sv
// Port checker for the interleaved backplane multiplexer
`timescale 1ns/10ps
module ibm_mux_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Words and pins
  input wire logic [15:0] src_valid,
  input wire logic [15:0] src_ready,
  input wire logic [15:0] rx_serial_oe,
  input wire logic [15:0] rx_signaling_oe,
  input wire logic [15:0] rx_channel_block
);
  // ****
  // Shadow of mode settings
  // ****
  logic gang_reg;
  logic [1:0] rate_reg;
  logic [15:0] en_reg;
  logic [1:0] calm_reg;
  logic wr;
  logic [2:0] mask;
  logic [15:0] lead;
  assign wr = psel && penable && pwrite && !paddr[15];
  assign mask = (rate_reg == 2'd0) ? 3'h1 : (rate_reg == 2'd1) ? 3'h3 : 3'h7;
  always_comb begin
    for (int l = 0; l < 16; l++) lead[l] = ((l % 8) & mask) == 0;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {gang_reg, rate_reg, en_reg, calm_reg} <= '0;
    end else begin
      calm_reg <= wr ? 2'd0 : (calm_reg == 2'd3 ? 2'd3 : calm_reg + 2'd1);
      if (wr && paddr[14:2] == 13'h00f0) gang_reg <= pwdata[0];
      if (wr && paddr[14:2] == 13'h00f1) rate_reg <= pwdata[1:0];
      if (wr && paddr[10:2] == 9'h088) en_reg[paddr[14:11]] <= pwdata[0];
    end
  end
  // ****
  // Assertions
  // ****
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_internal_lead_pins: assert property (calm_reg[1] && !gang_reg |->
    rx_serial_oe == (~en_reg | lead)) else $error("internal pin enables wrong");
  a_gang_one_owner: assert property (calm_reg[1] && gang_reg && rate_reg[1] |->
    $onehot0(rx_serial_oe[7:0] & en_reg[7:0])) else $error("two ganged pins drive");
  a_normal_own_pin: assert property (calm_reg[1] |-> &(rx_serial_oe | en_reg))
    else $error("normal pin not driven");
  a_sig_follows_data: assert property (rx_signaling_oe == rx_serial_oe)
    else $error("signaling enable differs");
  a_block_when_interleaved: assert property (calm_reg[1] |->
    (rx_channel_block & ~en_reg) == 0) else $error("channel block on normal port");
  a_gtcr_no_error: assert property (psel && penable && paddr == 16'h03c0 |->
    pready && !pslverr) else $error("global register refused");
  a_unmapped_error: assert property (psel && penable && paddr[15] |-> pslverr)
    else $error("unmapped access not refused");
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("wait state seen");
  a_full_after_take: assert property ($fell(src_ready[3]) |-> $past(src_valid[3]))
    else $error("ready fell without a word");
  c_gang_slot: cover property (gang_reg && rx_serial_oe[1]);
  c_fast_bus: cover property (rate_reg == 2'd2 && calm_reg[1] && !gang_reg);
  c_fifo_full: cover property ($fell(src_ready[3]));
endmodule : ibm_mux_monitor

// File: tb/ibm_bp_model.sv
// Backplane side system clock source
`timescale 1ns/10ps
module ibm_bp_model (
  // Frame control
  input wire logic run,
  // System clocks
  output logic [1:0] rx_clk,
  output logic [1:0] tx_clk
);
  logic ph;
  // Clocks stop low between frames
  initial begin
    {rx_clk, tx_clk, ph} = '0;
    #3;
    forever begin
      #16;
      ph = ~ph;
      if (ph && (run || rx_clk[0])) rx_clk = ~rx_clk;
      if (!ph && (run || tx_clk[0])) tx_clk = ~tx_clk;
    end
  end
endmodule : ibm_bp_model

// File: tb/ibm_mux_tb_top.sv
// Self-checking bench for the interleaved backplane multiplexer
`timescale 1ns/10ps
module ibm_mux_tb_top;
  // ****
  // Signals
  // ****
  typedef struct packed {logic [15:0] a; logic [31:0] w; logic [7:0] x; logic err;} ibm_row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [15:0] src_valid = 16'h0000;
  logic [15:0][15:0] src_data = '0;
  logic run = 1'b0;
  logic [31:0] prdata, r;
  logic pready, pslverr, e;
  logic [15:0] src_ready, ser, ser_oe, sig, sig_oe, rblk, tblk, seen, x;
  logic [1:0] rx_clk, tx_clk;
  logic [63:0] win_d, win_s;
  logic hit_d = 1'b0;
  logic hit_s = 1'b0;
  logic [63:0] want_d = 64'h0102_0304_0506_0708;
  logic [63:0] want_s = 64'h1112_1314_1516_1718;
  logic [63:0] want_m = 64'hffff_ffff_ffff_ffff;
  logic [3:0] bhi, blo;
  int pin = 3;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  int n, m;
  ibm_row_t rows [6] = '{
    '{16'h03c0, 32'h0000_0101, 8'h01, 1'b0},
    '{16'h03c4, 32'h0000_0102, 8'h02, 1'b0},
    '{16'h0220, 32'h0000_0103, 8'h03, 1'b0},
    '{16'h0620, 32'h0000_0103, 8'h03, 1'b0},
    '{16'h7a20, 32'h0000_0101, 8'h01, 1'b0},
    '{16'h8000, 32'h0000_01ff, 8'h00, 1'b1}};
  ibm_mux dut_u (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .src_valid, .src_data, .src_ready, .rx_system_clock(rx_clk),
    .tx_system_clock(tx_clk), .rx_serial_out(ser), .rx_serial_oe(ser_oe),
    .rx_signaling_out(sig), .rx_signaling_oe(sig_oe), .rx_channel_block(rblk),
    .tx_channel_block(tblk));
  ibm_bp_model bp_u (.run, .rx_clk, .tx_clk);
  always #2 clk = ~clk;
  // ****
  // Tasks
  // ****
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask : chk
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task do_reset;
    rst_b <= 1'b0;
    repeat (10) @(posedge clk);
    chk("ready in reset", 32'h0000_ffff, {16'h0000, src_ready});
    chk("oe in reset", 32'h0000_0000, {16'h0000, ser_oe});
    rst_b <= 1'b1;
  endtask : do_reset
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim;
    end
  end
  // Own port stream, first bit is the byte's top bit
  always @(negedge rx_clk[0]) begin
    win_d = {win_d[62:0], ser[pin]};
    win_s = {win_s[62:0], sig[pin]};
    if ((win_d & want_m) === want_d) hit_d = 1'b1;
    if ((win_s & want_m) === want_s) hit_s = 1'b1;
  end
  // ****
  // Tests
  // ****
  initial begin
    do_reset;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0000_0000);
      chk("reset value", 32'h0000_0000, r);
      apb(1'b1, rows[i].a, rows[i].w);
      chk("error flag", {31'h0, rows[i].err}, {31'h0, e});
      apb(1'b0, rows[i].a, 32'h0000_0000);
      chk("read back", {24'h0, rows[i].x}, r);
    end
    $display("test registers done");
    do_reset;
    src_data[3] <= 16'h1101;
    src_valid[3] <= 1'b1;
    n = 0;
    repeat (12) begin
      @(negedge clk);
      if (src_ready[3] === 1'b1) n++;
      @(posedge clk);
      src_data[3] <= {8'h11 + 8'(n), 8'h01 + 8'(n)};
    end
    src_valid[3] <= 1'b0;
    chk("words taken", 32'd8, n);
    apb(1'b0, 16'h03c8, 32'h0000_0000);
    chk("fifo status", 32'h0008_fff7, r);
    run <= 1'b1;
    repeat (1500) @(posedge clk);
    run <= 1'b0;
    apb(1'b0, 16'h03c8, 32'h0000_0000);
    chk("drained status", 32'h0000_ffff, r);
    chk("data stream", 32'h1, {31'h0, hit_d});
    chk("signaling stream", 32'h1, {31'h0, hit_s});
    $display("test own port done");
    for (int p = 0; p < 16; p++) apb(1'b1, 16'h0220 + 16'(p) * 16'h0800, 32'h0000_0001);
    for (int rt = 0; rt < 3; rt++) begin
      apb(1'b1, 16'h03c4, 32'(rt));
      repeat (4) @(posedge clk);
      m = (rt == 0) ? 1 : (rt == 1) ? 3 : 7;
      for (int l = 0; l < 16; l++) x[l] = ((l % 8) & m) == 0;
      chk("lead pins", {16'h0, x}, {16'h0, ser_oe});
      chk("signaling pins", {16'h0, x}, {16'h0, sig_oe});
    end
    $display("test internal rates done");
    apb(1'b1, 16'h03c0, 32'h0000_0001);
    run <= 1'b1;
    seen = 16'h0000;
    repeat (1500) begin
      @(posedge clk);
      seen |= ser_oe;
    end
    run <= 1'b0;
    chk("ganged pins seen", 32'h0000_ffff, {16'h0, seen});
    $display("test gang done");
    do_reset;
    apb(1'b1, 16'h0220, 32'h0000_0001);
    apb(1'b1, 16'h0a20, 32'h0000_0001);
    apb(1'b1, 16'h0620, 32'h0000_0001);
    apb(1'b1, 16'h0e20, 32'h0000_0001);
    for (int k = 0; k < 3; k++) begin
      src_valid[1:0] <= {1'b1, k < 2};
      src_data[0] <= {2{8'h11 + 8'(2 * k)}};
      src_data[1] <= {2{8'h10 + 8'(2 * k)}};
      @(posedge clk);
    end
    src_valid[1:0] <= 2'b00;
    chk("pair pins", 32'h0000_fffd, {16'h0, ser_oe});
    pin = 0;
    want_m = 64'h00ff_ffff_ffff_ffff;
    want_d = 64'h0010_1112_1314_ffff;
    want_s = want_d;
    hit_d = 1'b0;
    hit_s = 1'b0;
    {bhi, blo} = 8'h00;
    n = 0;
    run <= 1'b1;
    repeat (1300) begin
      @(negedge clk);
      bhi |= {tblk[1:0], rblk[1:0]};
      blo |= ~{tblk[1:0], rblk[1:0]};
      if ((rblk[1] == rblk[0]) || (tblk[1] == tblk[0])) n++;
    end
    @(posedge clk);
    run <= 1'b0;
    chk("pair data", 32'h1, {31'h0, hit_d});
    chk("pair signaling", 32'h1, {31'h0, hit_s});
    chk("blocks high", 32'hf, {28'h0, bhi});
    chk("blocks low", 32'hf, {28'h0, blo});
    chk("block overlap", 32'h0, n);
    $display("test internal pair done");
    end_sim;
  end
endmodule : ibm_mux_tb_top
bind ibm_mux ibm_mux_monitor mon_u (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .src_valid, .src_ready, .rx_serial_oe, .rx_signaling_oe, .rx_channel_block);
